/* hw/rmc_pkg.sv */
// Purpose: Constants, register map and types of the radio mode controller
// Assumes: 200 MHz system clock, SPI register access with 7-bit addresses
// Notes:   Long cycle counts are also top-level parameters for simulation
//
// Behaviour
// - Power-on bit set moves power down into standby-I.
// - Active modes need enable high; enable low returns to standby-I.
// - Transmitter with enable high and empty FIFO idles in standby-II.
// - Registers and SPI stay usable in both standby modes.
// - Receive entered only with power-on, receive-select and enable high.
// - Store valid packets in free RX slot, drop when RX FIFO full.
// - Receive held until host leaves it, or protocol timeout ends it.
// - Power flag rises only after detector high for 40 us.
// - Transmit needs power-on, receive-select low, payload, enable >10 us.
// - After a packet: standby-I, next packet, or standby-II; the code enters RX settling instead when receive-select is set.
// - Transmit never lasts longer than 4 ms continuously.
// - Enable held high drains the TX FIFO while the host refills it.
// - Standby-II transmits when chip select rises after an upload.
// - Enable low gives standby-I only after the packet in flight ends.
// - Standby or TX/RX switch to TX or RX settles within 130 us.
// - Air rate selects 250 kbps, 1 Mbps or 2 Mbps.
// - Carrier frequency in MHz equals 2400 plus channel number.
// - Power flag at register 09 bit 0, zero below threshold.
// - Power flag latched on valid packet or at end of receive.
// - Power-on bit clear gives power down, registers and SPI kept.

package rmc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int T_THCE_NS      = 10000;
  localparam int T_STBY2A_NS    = 130000;
  localparam int T_AGC_NS       = 40000;
  localparam int T_TX_MAX_NS    = 4000000;
  // Least times round up, longest times round down
  localparam int THCE_CYC   = (T_THCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY2A_CYC = T_STBY2A_NS / CLK_PERIOD_NS;
  localparam int AGC_CYC    = (T_AGC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_MAX_CYC = T_TX_MAX_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_CONFIG      = 7'h00;
  localparam logic [6:0] ADDR_CHANNEL     = 7'h05;
  localparam logic [6:0] ADDR_RADIO_SETUP = 7'h06;
  localparam logic [6:0] ADDR_MODE        = 7'h07;
  localparam logic [6:0] ADDR_RX_POWER    = 7'h09;
  localparam logic [6:0] ADDR_TX_PAYLOAD  = 7'h20;
  localparam int CFG_POWER_ON_BIT  = 1;
  localparam int CFG_RX_SELECT_BIT = 0;
  localparam int RX_POWER_BIT      = 0;
  localparam logic [1:0] CONFIG_RST  = 2'h0;
  localparam logic [6:0] CHANNEL_RST = 7'h02;
  localparam logic [1:0] RATE_1M     = 2'h0;
  localparam logic [1:0] RATE_2M     = 2'h1;
  localparam logic [1:0] RATE_250K   = 2'h2;
  localparam logic [11:0] FREQ_BASE_MHZ = 12'h960;

  typedef enum logic [2:0] {
    MODE_POWER_DOWN,
    MODE_STANDBY_1,
    MODE_STANDBY_2,
    MODE_RX_SETTLE,
    MODE_RX,
    MODE_TX_SETTLE,
    MODE_TX
  } rmc_mode_t;

endpackage

/* hw/rmc_reg_if.sv */
// Purpose: Register access carrier between SPI slave and mode controller
// Assumes: Single clock domain
// Notes:   wr_stb and frame_end are one-cycle pulses

`timescale 1ns/1ps

interface rmc_reg_if;
  logic       wr_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       frame_end;

  modport spi  (output wr_stb, output addr, output wdata,
                output frame_end, input rdata);
  modport regs (input wr_stb, input addr, input wdata,
                input frame_end, output rdata);
endinterface

/* hw/rmc_spi_slave.sv */
// Purpose: SPI mode 0 slave, command byte then one or more data bytes, MSB first
// Assumes: SPI pins synchronous to clk_sys, sclk well below clk_sys / 2
// Notes:   Command bit 7 set means write, bits 6:0 are the address

`timescale 1ns/1ps

module rmc_spi_slave
  import rmc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // SPI pins
  input  wire logic spi_sclk,
  input  wire logic spi_mosi,
  input  wire logic spi_csn_n,
  output logic      spi_miso,
  output logic      spi_miso_oe,
  // Register side
  rmc_reg_if.spi    bus
);

  logic       sclk_q,  sclk_d;
  logic       csn_q,   csn_d;
  logic [3:0] bit_q,   bit_d;
  logic [7:0] sh_q,    sh_d;
  logic       wr_q,    wr_d;
  logic [6:0] addr_q,  addr_d;
  logic [7:0] tx_q,    tx_d;
  logic       stb_q,   stb_d;
  logic       end_q,   end_d;
  logic       rise;
  logic       fall;

  assign rise = spi_sclk & ~sclk_q & ~spi_csn_n;
  assign fall = ~spi_sclk & sclk_q & ~spi_csn_n;

  always_comb
  begin
    sclk_d = spi_sclk;
    csn_d  = spi_csn_n;
    bit_d  = bit_q;
    sh_d   = sh_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    tx_d   = tx_q;
    stb_d  = 1'b0;
    end_d  = spi_csn_n & ~csn_q;
    if (spi_csn_n)
      bit_d = 4'h0;
    else if (rise)
    begin
      sh_d  = {sh_q[6:0], spi_mosi};
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h7)
      begin
        wr_d   = sh_q[6];
        addr_d = {sh_q[5:0], spi_mosi};
      end
      if (bit_q == 4'hF)
      begin
        stb_d = wr_q;
        bit_d = 4'h8;
      end
    end
    // Read data loads once the address is known, shifts on falling edges
    if (fall)
      tx_d = (bit_q == 4'h8) ? bus.rdata : {tx_q[6:0], 1'b0};
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      wr_q   <= 1'b0;
      addr_q <= 7'h00;
      tx_q   <= 8'h00;
      stb_q  <= 1'b0;
      end_q  <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_d;
      csn_q  <= csn_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      tx_q   <= tx_d;
      stb_q  <= stb_d;
      end_q  <= end_d;
    end
  end

  assign spi_miso      = tx_q[7];
  assign spi_miso_oe   = ~csn_q;
  assign bus.wr_stb    = stb_q;
  assign bus.addr      = addr_q;
  assign bus.wdata     = sh_q;
  assign bus.frame_end = end_q;

endmodule

/* hw/rmc_rpd_filter.sv */
// Purpose: Persistence filter on the raw received power detector
// Assumes: Raw level synchronous to clk_sys
// Notes:   Any drop of the raw level restarts the persistence window

`timescale 1ns/1ps

module rmc_rpd_filter
  import rmc_pkg::*;
#(
  parameter int unsigned AGC_CYCLES = AGC_CYC
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Detector
  input  wire logic enable,
  input  wire logic raw_level,
  output logic      filtered
);

  logic [15:0] cnt_q, cnt_d;
  logic        hit;

  assign hit = (cnt_q == 16'(AGC_CYCLES));

  always_comb
  begin
    cnt_d = 16'h0000;
    if (enable && raw_level)
      cnt_d = hit ? cnt_q : cnt_q + 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  assign filtered = hit;

endmodule

/* hw/rmc_radio_mode_ctrl.sv */
// Purpose: Operating mode state machine and radio settings of a transceiver
// Assumes: External packet engine and FIFOs; all pins synchronous to clk_sys
// Notes:   Mode, channel, rate and power flag are reached over SPI

`timescale 1ns/1ps

module rmc_radio_mode_ctrl
  import rmc_pkg::*;
#(
  parameter int unsigned STBY2A_CYCLES = STBY2A_CYC,
  parameter int unsigned AGC_CYCLES    = AGC_CYC,
  parameter int unsigned TX_MAX_CYCLES = TX_MAX_CYC
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Host pins
  input  wire logic        chip_enable,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  input  wire logic        spi_csn_n,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // TX FIFO and packet engine
  input  wire logic        tx_fifo_empty,
  input  wire logic        tx_pkt_done,
  output logic             tx_push,
  output logic [7:0]       tx_byte,
  output logic             tx_pkt_start,
  output logic             tx_abort,
  // RX path
  input  wire logic        rx_pkt_valid,
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_timeout,
  input  wire logic        rpd_raw,
  output logic             rx_store,
  output logic             rx_drop,
  // Radio control
  output logic             osc_on,
  output logic             pll_on,
  output logic             tx_on,
  output logic             rx_on,
  output logic [1:0]       air_rate,
  output logic [11:0]      carrier_mhz
);

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  rmc_reg_if bus ();

  rmc_spi_slave u_spi (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .spi_sclk    (spi_sclk),
    .spi_mosi    (spi_mosi),
    .spi_csn_n   (spi_csn_n),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .bus         (bus)
  );

  logic        rpd_filt;
  rmc_mode_t   st_q,     st_d;
  logic [1:0]  cfg_q,    cfg_d;
  logic [6:0]  chan_q,   chan_d;
  logic [1:0]  rate_q,   rate_d;
  logic        rpd_q,    rpd_d;
  logic        hold_q,   hold_d;
  logic        upl_q,    upl_d;
  logic [19:0] tmr_q,    tmr_d;
  logic [11:0] ceh_q,    ceh_d;
  logic [11:0] mhz_q,    mhz_d;
  logic        push_q,   push_d;
  logic [7:0]  byte_q,   byte_d;
  logic        start_q,  start_d;
  logic        abort_q,  abort_d;
  logic        store_q,  store_d;
  logic        drop_q,   drop_d;
  logic        osc_q,    osc_d;
  logic        pll_q,    pll_d;
  logic        txon_q,   txon_d;
  logic        rxon_q,   rxon_d;
  logic        pwr;
  logic        rxsel;
  logic        in_rx;
  logic        tmr_settled;
  logic        tx_limit;

  assign pwr   = cfg_q[CFG_POWER_ON_BIT];
  assign rxsel = cfg_q[CFG_RX_SELECT_BIT];
  assign in_rx = (st_q == MODE_RX);
  assign tmr_settled = (tmr_q == 20'(STBY2A_CYCLES - 1));
  assign tx_limit    = (tmr_q == 20'(TX_MAX_CYCLES - 1));

  rmc_rpd_filter #(
    .AGC_CYCLES (AGC_CYCLES)
  ) u_rpd (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .enable    (in_rx),
    .raw_level (rpd_raw),
    .filtered  (rpd_filt)
  );

  // Readable in every mode; registers are never cleared by mode changes
  always_comb
  begin
    unique case (bus.addr)
      ADDR_CONFIG:      bus.rdata = {6'h00, cfg_q};
      ADDR_CHANNEL:     bus.rdata = {1'b0, chan_q};
      ADDR_RADIO_SETUP: bus.rdata = {6'h00, rate_q};
      ADDR_MODE:        bus.rdata = {5'h00, st_q};
      ADDR_RX_POWER:    bus.rdata = {7'h00, rpd_q};
      default:          bus.rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_comb
  begin
    cfg_d  = cfg_q;
    chan_d = chan_q;
    rate_d = rate_q;
    push_d = 1'b0;
    byte_d = byte_q;
    upl_d  = upl_q;
    if (bus.wr_stb)
    begin
      unique case (bus.addr)
        ADDR_CONFIG:      cfg_d  = bus.wdata[1:0];
        ADDR_CHANNEL:     chan_d = bus.wdata[6:0];
        ADDR_RADIO_SETUP: rate_d = bus.wdata[1:0];
        ADDR_TX_PAYLOAD:
        begin
          push_d = 1'b1;
          byte_d = bus.wdata;
          upl_d  = 1'b1;
        end
        default:          cfg_d  = cfg_q;
      endcase
    end
    if (bus.frame_end)
      upl_d = 1'b0;
    mhz_d = FREQ_BASE_MHZ + {5'h00, chan_q};
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q  <= CONFIG_RST;
      chan_q <= CHANNEL_RST;
      rate_q <= RATE_1M;
      push_q <= 1'b0;
      byte_q <= 8'h00;
      upl_q  <= 1'b0;
      mhz_q  <= FREQ_BASE_MHZ;
    end
    else
    begin
      cfg_q  <= cfg_d;
      chan_q <= chan_d;
      rate_q <= rate_d;
      push_q <= push_d;
      byte_q <= byte_d;
      upl_q  <= upl_d;
      mhz_q  <= mhz_d;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    ceh_d   = chip_enable ? ceh_q : 12'h000;
    if (chip_enable && ceh_q != 12'(THCE_CYC))
      ceh_d = ceh_q + 12'h001;
    unique case (st_q)
      MODE_POWER_DOWN:
        if (pwr)
          st_d = MODE_STANDBY_1;
      MODE_STANDBY_1:
        if (chip_enable && rxsel)
          st_d = MODE_RX_SETTLE;
        else if (!rxsel && !tx_fifo_empty && ceh_q == 12'(THCE_CYC))
          st_d = MODE_TX_SETTLE;
        else if (chip_enable && !rxsel && tx_fifo_empty)
          st_d = MODE_STANDBY_2;
      MODE_STANDBY_2:
        if (!chip_enable)
          st_d = MODE_STANDBY_1;
        else if (rxsel)
          st_d = MODE_RX_SETTLE;
        else if (upl_q && bus.frame_end && !tx_fifo_empty)
          st_d = MODE_TX_SETTLE;
      MODE_RX_SETTLE:
        if (!chip_enable)
          st_d = MODE_STANDBY_1;
        else if (tmr_settled)
          st_d = MODE_RX;
      MODE_RX:
        if (!chip_enable || rx_timeout)
          st_d = MODE_STANDBY_1;
        else if (!rxsel)
          st_d = tx_fifo_empty ? MODE_STANDBY_2 : MODE_TX_SETTLE;
      MODE_TX_SETTLE:
        if (tmr_settled)
        begin
          st_d    = MODE_TX;
          start_d = 1'b1;
        end
      MODE_TX:
        // Open-loop PLL drifts: cut transmit short at the limit
        if (tx_limit)
        begin
          st_d    = MODE_STANDBY_1;
          abort_d = 1'b1;
        end
        else if (tx_pkt_done)
        begin
          if (!chip_enable)
            st_d = MODE_STANDBY_1;
          else if (rxsel)
            st_d = MODE_RX_SETTLE;
          else if (!tx_fifo_empty)
            start_d = 1'b1;
          else
            st_d = MODE_STANDBY_2;
        end
    endcase
    if (!pwr)
    begin
      st_d    = MODE_POWER_DOWN;
      start_d = 1'b0;
      abort_d = (st_q == MODE_TX);
    end
    // One timer serves settling and the transmit limit; TX keeps counting
    // across back-to-back packets since the PLL never relocks there
    tmr_d = (st_d == st_q) ? tmr_q + 20'h00001 : 20'h00000;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q    <= MODE_POWER_DOWN;
      tmr_q   <= 20'h00000;
      ceh_q   <= 12'h000;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      ceh_q   <= ceh_d;
      start_q <= start_d;
      abort_q <= abort_d;
    end
  end

  // ------------------------------------------------------------
  // Receive path and power flag
  // ------------------------------------------------------------
  always_comb
  begin
    store_d = in_rx && rx_pkt_valid && !rx_fifo_full;
    drop_d  = in_rx && rx_pkt_valid && rx_fifo_full;
    rpd_d   = rpd_q;
    hold_d  = hold_q;
    if (st_q == MODE_RX_SETTLE)
      hold_d = 1'b0;
    if (in_rx && !hold_q)
    begin
      rpd_d = rpd_filt;
      // Freeze on a good packet or when the receive period ends
      if (rx_pkt_valid || st_d != MODE_RX)
        hold_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      store_q <= 1'b0;
      drop_q  <= 1'b0;
      rpd_q   <= 1'b0;
      hold_q  <= 1'b0;
    end
    else
    begin
      store_q <= store_d;
      drop_q  <= drop_d;
      rpd_q   <= rpd_d;
      hold_q  <= hold_d;
    end
  end

  // ------------------------------------------------------------
  // Radio enables, registered from the next mode
  // ------------------------------------------------------------
  always_comb
  begin
    osc_d  = (st_d != MODE_POWER_DOWN);
    pll_d  = (st_d != MODE_POWER_DOWN) && (st_d != MODE_STANDBY_1)
             && (st_d != MODE_STANDBY_2);
    txon_d = (st_d == MODE_TX);
    rxon_d = (st_d == MODE_RX);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_q  <= 1'b0;
      pll_q  <= 1'b0;
      txon_q <= 1'b0;
      rxon_q <= 1'b0;
    end
    else
    begin
      osc_q  <= osc_d;
      pll_q  <= pll_d;
      txon_q <= txon_d;
      rxon_q <= rxon_d;
    end
  end

  assign tx_push      = push_q;
  assign tx_byte      = byte_q;
  assign tx_pkt_start = start_q;
  assign tx_abort     = abort_q;
  assign rx_store     = store_q;
  assign rx_drop      = drop_q;
  assign osc_on       = osc_q;
  assign pll_on       = pll_q;
  assign tx_on        = txon_q;
  assign rx_on        = rxon_q;
  assign air_rate     = rate_q;
  assign carrier_mhz  = mhz_q;

endmodule

/* tb/rmc_radio_mode_ctrl_monitor.sv */
// Purpose: Concurrent checks on the mode controller top ports
// Assumes: One clock domain, reset_n asynchronous and active low
// Notes:   Settle and transmit spans are counted in helper logic

`timescale 1ns/1ps

module rmc_radio_mode_ctrl_monitor #(
  parameter int unsigned STBY2A_CYCLES = 20,
  parameter int unsigned TX_MAX_CYCLES = 200
)
(
  // Clock and reset
  input logic clk_sys,
  input logic reset_n,
  // Stimulus
  input logic chip_enable,
  input logic rx_pkt_valid,
  input logic rx_fifo_full,
  input logic rx_timeout,
  // Results
  input logic rx_store,
  input logic rx_drop,
  input logic tx_pkt_start,
  input logic tx_abort,
  input logic osc_on,
  input logic pll_on,
  input logic tx_on,
  input logic rx_on
);
  // ------------------------------------------------------------
  // Span counters and properties
  // ------------------------------------------------------------
  int unsigned tx_cnt_q, tx_cnt_d, set_cnt_q, set_cnt_d;

  always_comb
  begin
    tx_cnt_d  = tx_on ? tx_cnt_q + 1 : 0;
    set_cnt_d = (pll_on && !tx_on && !rx_on) ? set_cnt_q + 1 : 0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_cnt_q  <= 0;
      set_cnt_q <= 0;
    end
    else
    begin
      tx_cnt_q  <= tx_cnt_d;
      set_cnt_q <= set_cnt_d;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  power_gate_a: assert property (!osc_on |-> !pll_on && !tx_on && !rx_on)
    else $error("radio path on while powered down");
  rx_exit_a: assert property (rx_on && (!chip_enable || rx_timeout)
    |-> ##[1:2] !rx_on) else $error("receive not left");
  store_cause_a: assert property (rx_store |->
    $past(rx_pkt_valid && !rx_fifo_full)) else $error("store uncaused");
  drop_cause_a: assert property (rx_drop |->
    $past(rx_pkt_valid && rx_fifo_full)) else $error("drop uncaused");
  tx_start_a: assert property ($rose(tx_on) |-> ##[0:2] tx_pkt_start)
    else $error("no packet start on transmit entry");
  abort_cause_a: assert property (tx_abort |-> $past(pll_on))
    else $error("abort outside transmit");
  tx_limit_a: assert property (tx_cnt_q <= TX_MAX_CYCLES + 1)
    else $error("transmit too long");
  settle_max_a: assert property (set_cnt_q <= STBY2A_CYCLES + 2)
    else $error("settling too long");
  settle_min_a: assert property ($rose(tx_on) |-> $past(pll_on, 8))
    else $error("transmit without settling");

  cover property (rx_store);
  cover property (tx_abort);
  cover property ($rose(tx_on));
endmodule

bind rmc_radio_mode_ctrl rmc_radio_mode_ctrl_monitor #(
  .STBY2A_CYCLES(STBY2A_CYCLES),
  .TX_MAX_CYCLES(TX_MAX_CYCLES)
) mon_u (.clk_sys, .reset_n, .chip_enable, .rx_pkt_valid, .rx_fifo_full,
  .rx_timeout, .rx_store, .rx_drop, .tx_pkt_start, .tx_abort, .osc_on,
  .pll_on, .tx_on, .rx_on);

/* tb/rmc_host_model.sv */
// Purpose: Host side of the pins: enable line and SPI mode 0 master
// Assumes: Driven at falling clk_sys edges, external clock reference
// Notes:   Read results come out as a one-cycle rd_valid pulse

`timescale 1ns/1ps

module rmc_host_model #(
  parameter int unsigned PD2STBY_CYC = 30000,
  parameter int unsigned CE2CS_CYC   = 800,
  parameter int unsigned HALF_CYC    = 5
)
(
  // Clock
  input  logic       clk_sys,
  // Device pins
  output logic       chip_enable,
  output logic       spi_sclk,
  output logic       spi_mosi,
  output logic       spi_csn_n,
  input  logic       spi_miso,
  // Read results
  output logic       rd_valid,
  output logic [7:0] rd_data
);
  // ------------------------------------------------------------
  // Pin sequencing
  // ------------------------------------------------------------
  int unsigned ce_age_q;

  initial
  begin
    chip_enable = 1'b0;
    spi_sclk    = 1'b0;
    spi_mosi    = 1'b0;
    spi_csn_n   = 1'b1;
    rd_valid    = 1'b0;
    rd_data     = 8'h00;
  end

  always @(posedge clk_sys)
    ce_age_q <= chip_enable ? ce_age_q + 1 : 0;

  task automatic set_ce(input logic v);
    chip_enable = v;
  endtask

  // Oscillator start is the host's job, the device does not time it
  task automatic pwr_wait;
    repeat (PD2STBY_CYC) @(negedge clk_sys);
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
    logic [15:0] sh;
    logic [7:0]  rx;
    sh = {cmd, dat};
    @(negedge clk_sys);
    rd_valid = 1'b0;
    while (chip_enable && ce_age_q < CE2CS_CYC) @(negedge clk_sys);
    spi_csn_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi = sh[i];
      repeat (HALF_CYC) @(negedge clk_sys);
      spi_sclk = 1'b1;
      if (i < 8)
        rx[i] = spi_miso;
      repeat (HALF_CYC) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (HALF_CYC) @(negedge clk_sys);
    spi_csn_n = 1'b1;
    // Released line must not keep a stale level
    spi_mosi  = ~spi_mosi;
    rd_data   = rx;
    rd_valid  = !cmd[7];
    @(negedge clk_sys);
    rd_valid  = 1'b0;
  endtask
endmodule

/* tb/rmc_radio_mode_ctrl_tb.sv */
// Purpose: Self-checking bench of the radio mode controller
// Assumes: Shortened settle, filter and transmit limits
// Notes:   Reads and payload bytes are checked through a note queue

`timescale 1ns/1ps

module rmc_radio_mode_ctrl_tb
  import rmc_pkg::*;
;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  localparam int unsigned STBY  = 20;
  localparam int unsigned AGC   = 10;
  localparam int unsigned TXMAX = 200;
  logic        clk_sys, reset_n, chip_enable, spi_sclk, spi_mosi;
  logic        spi_csn_n, spi_miso, tx_fifo_empty, tx_pkt_done, tx_push;
  logic        tx_pkt_start, tx_abort, rx_pkt_valid, rx_fifo_full;
  logic        rx_timeout, rpd_raw, rx_store, rx_drop, osc_on, pll_on;
  logic        tx_on, rx_on, rd_valid, spi_miso_oe;
  logic [7:0]  tx_byte, rd_data;
  logic [1:0]  air_rate;
  logic [11:0] carrier_mhz;
  logic [1:0]  rates [3] = '{RATE_1M, RATE_2M, RATE_250K};
  logic [11:0] exp_q [$];
  string       nm_q [$];
  int unsigned failures, compares, n_start, n_store, n_drop, n_abort;

  rmc_radio_mode_ctrl #(.STBY2A_CYCLES(STBY), .AGC_CYCLES(AGC),
    .TX_MAX_CYCLES(TXMAX)) dut_u (.clk_sys, .reset_n, .chip_enable,
    .spi_sclk, .spi_mosi, .spi_csn_n, .spi_miso, .spi_miso_oe,
    .tx_fifo_empty, .tx_pkt_done, .tx_push, .tx_byte, .tx_pkt_start,
    .tx_abort, .rx_pkt_valid, .rx_fifo_full, .rx_timeout, .rpd_raw,
    .rx_store, .rx_drop, .osc_on, .pll_on, .tx_on, .rx_on, .air_rate,
    .carrier_mhz);

  rmc_host_model host_u (.clk_sys, .chip_enable, .spi_sclk, .spi_mosi,
    .spi_csn_n, .spi_miso, .rd_valid, .rd_data);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic clk(input int unsigned n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b1, a}, d);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    exp_q.push_back({4'h0, e});
    nm_q.push_back(n);
    host_u.xfer({1'b0, a}, 8'h00);
    clk(2);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    clk(1);
    s = 1'b0;
  endtask

  // Oldest note is matched against each read or payload byte
  always @(posedge clk_sys)
  begin
    n_start += (tx_pkt_start === 1'b1);
    n_store += (rx_store === 1'b1);
    n_drop  += (rx_drop === 1'b1);
    n_abort += (tx_abort === 1'b1);
    if (rd_valid === 1'b1 || tx_push === 1'b1)
      chk(nm_q.pop_front(), exp_q.pop_front(),
          {4'h0, rd_valid ? rd_data : tx_byte});
  end

  initial
  begin
    clk(60000);
    failures++;
    test_done();
  end

  initial
  begin
    logic [6:0] ch;
    logic [7:0] pb;
    void'($urandom(32'h1FD6));
    reset_n       = 1'b0;
    tx_fifo_empty = 1'b1;
    // Outside receive and transmit these must leave the modes untouched
    tx_pkt_done   = 1'($urandom);
    rx_pkt_valid  = 1'($urandom);
    rx_fifo_full  = 1'($urandom);
    rx_timeout    = 1'($urandom);
    rpd_raw       = 1'($urandom);
    clk(6);
    reset_n = 1'b1;
    clk(2);
    rd(ADDR_MODE, 8'h00, "mode");
    rd(ADDR_CHANNEL, {1'b0, CHANNEL_RST}, "channel");
    rd(ADDR_RX_POWER, 8'h00, "power flag");
    rd(7'h11, 8'h00, "unmapped");
    foreach (rates[i])
    begin
      wr(ADDR_RADIO_SETUP, {6'h00, rates[i]});
      clk(3);
      chk("air_rate", {10'h000, rates[i]}, {10'h000, air_rate});
    end
    ch = 7'($urandom_range(127, 0));
    wr(ADDR_CHANNEL, {1'b0, ch});
    clk(3);
    chk("carrier", FREQ_BASE_MHZ + {5'h00, ch}, carrier_mhz);
    $display("test registers done");
    tx_pkt_done   = 1'b0;
    rx_pkt_valid  = 1'b0;
    rx_fifo_full  = 1'b0;
    rx_timeout    = 1'b0;
    rpd_raw       = 1'b0;
    wr(ADDR_CONFIG, 8'h02);
    wr(ADDR_MODE, 8'h00);
    clk(3);
    chk("osc_on", 12'h001, {11'h000, osc_on});
    chk("miso_oe", 12'h000, {11'h000, spi_miso_oe});
    rd(ADDR_MODE, 8'h01, "mode");
    rd(ADDR_CONFIG, 8'h02, "config");
    host_u.pwr_wait();
    $display("test power up done");
    wr(ADDR_CONFIG, 8'h03);
    host_u.set_ce(1'b1);
    clk(STBY + 4);
    chk("rx_on", 12'h001, {11'h000, rx_on});
    rpd_raw = 1'b1;
    clk($urandom_range(8, 1));
    rpd_raw = 1'b0;
    rd(ADDR_RX_POWER, 8'h00, "power flag");
    rpd_raw = 1'b1;
    clk(AGC + 4);
    pulse(rx_pkt_valid);
    rpd_raw = 1'b0;
    rd(ADDR_RX_POWER, 8'h01, "power flag");
    rx_fifo_full = 1'b1;
    pulse(rx_pkt_valid);
    rx_fifo_full = 1'b0;
    clk(2);
    chk("stored", 12'h001, 12'(n_store));
    chk("dropped", 12'h001, 12'(n_drop));
    rd(ADDR_MODE, 8'h04, "mode");
    pulse(rx_timeout);
    clk(1);
    chk("rx_on", 12'h000, {11'h000, rx_on});
    clk(STBY + 4);
    host_u.set_ce(1'b0);
    clk(3);
    chk("rx_on", 12'h000, {11'h000, rx_on});
    $display("test receive done");
    wr(ADDR_CONFIG, 8'h02);
    tx_fifo_empty = 1'b0;
    host_u.set_ce(1'b1);
    clk(100);
    host_u.set_ce(1'b0);
    clk(THCE_CYC + 30);
    chk("tx_on", 12'h000, {11'h000, tx_on});
    host_u.set_ce(1'b1);
    clk(THCE_CYC + STBY + 8);
    host_u.set_ce(1'b0);
    clk(3);
    chk("tx_on", 12'h001, {11'h000, tx_on});
    chk("starts", 12'h001, 12'(n_start));
    pulse(tx_pkt_done);
    clk(2);
    chk("tx_on", 12'h000, {11'h000, tx_on});
    rd(ADDR_MODE, 8'h01, "mode");
    $display("test transmit pulse done");
    tx_fifo_empty = 1'b1;
    host_u.set_ce(1'b1);
    clk(10);
    rd(ADDR_MODE, 8'h02, "mode");
    pb = 8'($urandom);
    exp_q.push_back({4'h0, pb});
    nm_q.push_back("tx_byte");
    // FIFO model holds the byte before the frame ends
    tx_fifo_empty = 1'b0;
    wr(ADDR_TX_PAYLOAD, pb);
    clk(STBY + 8);
    chk("tx_on", 12'h001, {11'h000, tx_on});
    pulse(tx_pkt_done);
    clk(3);
    chk("starts", 12'h003, 12'(n_start));
    tx_fifo_empty = 1'b1;
    clk(TXMAX + 10);
    chk("aborts", 12'h001, 12'(n_abort));
    chk("tx_on", 12'h000, {11'h000, tx_on});
    host_u.set_ce(1'b0);
    $display("test standby two done");
    wr(ADDR_CONFIG, 8'h00);
    clk(3);
    chk("osc_on", 12'h000, {11'h000, osc_on});
    rd(ADDR_CHANNEL, {1'b0, ch}, "channel");
    $display("test power down done");
    test_done();
  end
endmodule
